// ---- pkg/qioe_pkg.sv ----
// Purpose: Shared constants and types for the quad I/O expander core
// Assumes: 100 MHz ref_clk_i, serial bus sampled by that clock
// Notes:   Upper nibble values are what reads return in unused bits

package qioe_pkg;

	// ------------------------------------------------------------
	// Widths and addressing
	// ------------------------------------------------------------
	localparam int         NPIN      = 4;
	localparam int         SYNC_W    = 7;
	localparam int         SYNC_SCL  = 0;
	localparam int         SYNC_SDA  = 1;
	localparam int         SYNC_RSTN = 2;
	localparam int         SYNC_PIN  = 3;
	// Bus target address, value is an arbitrary choice
	localparam logic [6:0] DEV_ADDR  = 7'h49;
	localparam logic [3:0] BIT_LAST  = 4'h8;
	localparam logic [3:0] BIT_ZERO  = 4'h0;

	// ------------------------------------------------------------
	// Command codes and register defaults
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_INPUT  = 8'h00;
	localparam logic [7:0] CMD_OUTPUT = 8'h01;
	localparam logic [7:0] CMD_POLAR  = 8'h02;
	localparam logic [7:0] CMD_DIR    = 8'h03;
	localparam logic [7:0] CMD_RST    = 8'h00;
	localparam logic [3:0] OUT_RST    = 4'hf;
	localparam logic [3:0] POL_RST    = 4'h0;
	localparam logic [3:0] DIR_RST    = 4'hf;
	localparam logic [3:0] IN_PAD     = 4'hf;
	localparam logic [3:0] OUT_PAD    = 4'hf;
	localparam logic [3:0] POL_PAD    = 4'h0;
	localparam logic [3:0] DIR_PAD    = 4'hf;
	localparam logic [7:0] UNMAP_RD   = 8'hff;
	localparam logic [6:0] SYNC_RST   = 7'h07;

	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_ADDR  = 9'h002,
		ST_AACK  = 9'h004,
		ST_CMD   = 9'h008,
		ST_CACK  = 9'h010,
		ST_WDAT  = 9'h020,
		ST_WACK  = 9'h040,
		ST_RDAT  = 9'h080,
		ST_RACK  = 9'h100
	} qioe_state_e;

endpackage

// ---- pkg/qioe_sync_if.sv ----
// Purpose: Carries synchronised pin levels and bus events to the core
// Assumes: Producer and consumer share ref_clk_i
// Notes:   Event strobes are one-cycle pulses

`timescale 1ns/10ps

interface qioe_sync_if;
	logic       scl;
	logic       sda;
	logic       rst_n;
	logic [3:0] pins;
	logic       scl_rise;
	logic       scl_fall;
	logic       start;
	logic       stop;

	modport src (output scl, sda, rst_n, pins, scl_rise, scl_fall, start, stop);
	modport dst (input  scl, sda, rst_n, pins, scl_rise, scl_fall, start, stop);
endinterface

// ---- hw/qioe_sync.sv ----
// Purpose: Three-stage synchronisers and bus event detection
// Assumes: All raw inputs are asynchronous to ref_clk_i
// Notes:   A level is accepted once stages two and three agree

`timescale 1ns/10ps

module qioe_sync (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       reset_n_i,
	input  wire logic [3:0] io_i,
	qioe_sync_if.src        sync
);

	logic [qioe_pkg::SYNC_W-1:0] raw;
	logic [qioe_pkg::SYNC_W-1:0] filt;
	logic                        scl_prev_reg;
	logic                        sda_prev_reg;

	assign raw = {io_i, reset_n_i, sda_i, scl_i};

	// ------------------------------------------------------------
	// Per-bit synchroniser
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < qioe_pkg::SYNC_W; g++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic flt_reg;
			// three flops per input
			// No reset: the chain keeps tracking its input during reset, so the
			// change reference loaded then already matches the pins at release
			always_ff @(posedge ref_clk_i) begin
				s1_reg <= raw[g];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
			end
			// Only stages two and three judge a change
			always_ff @(posedge ref_clk_i) begin
				if (s2_reg == s3_reg)
					flt_reg <= s3_reg;
			end
			assign filt[g] = flt_reg;
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			scl_prev_reg <= qioe_pkg::SYNC_RST[qioe_pkg::SYNC_SCL];
			sda_prev_reg <= qioe_pkg::SYNC_RST[qioe_pkg::SYNC_SDA];
		end else begin
			scl_prev_reg <= filt[qioe_pkg::SYNC_SCL];
			sda_prev_reg <= filt[qioe_pkg::SYNC_SDA];
		end
	end

	assign sync.scl      = filt[qioe_pkg::SYNC_SCL];
	assign sync.sda      = filt[qioe_pkg::SYNC_SDA];
	assign sync.rst_n    = filt[qioe_pkg::SYNC_RSTN];
	assign sync.pins     = filt[qioe_pkg::SYNC_PIN +: qioe_pkg::NPIN];
	assign sync.scl_rise = sync.scl & ~scl_prev_reg;
	assign sync.scl_fall = ~sync.scl & scl_prev_reg;
	assign sync.start    = sync.scl & scl_prev_reg & sda_prev_reg & ~sync.sda;
	assign sync.stop     = sync.scl & scl_prev_reg & ~sda_prev_reg & sync.sda;

endmodule

// ---- hw/qioe_core.sv ----
// Purpose: Four-bit I/O expander behind a two-wire serial target port
// Assumes: ref_clk_i at 100 MHz, at least 16x the serial clock
// Notes:   Open-drain lines are split into level, enable pairs

`timescale 1ns/10ps

module qioe_core (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       reset_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	output logic            int_o,
	output logic            int_oe_o,
	input  wire logic [3:0] io_i,
	output logic      [3:0] io_o,
	output logic      [3:0] io_oe_o,
	output logic      [3:0] pin_driver_a_o,
	output logic      [3:0] pin_driver_b_o
);

	qioe_sync_if sync ();

	qioe_pkg::qioe_state_e state_reg;
	logic [3:0]            bitcnt_reg;
	logic [7:0]            shift_reg;
	logic                  rw_reg;
	logic                  mack_reg;
	logic [7:0]            ptr_reg;
	logic                  sda_oe_reg;
	logic [3:0]            out_reg;
	logic [3:0]            pol_reg;
	logic [3:0]            dir_reg;
	logic [3:0]            ref_reg;
	logic                  int_reg;
	logic [3:0]            io_reg;
	logic [3:0]            io_oe_reg;
	logic [3:0]            drv_a_reg;
	logic [3:0]            drv_b_reg;
	logic                  low_reg;
	logic                  core_rst;
	logic                  wr_go;
	logic                  rd_load;
	logic                  snap;
	logic [7:0]            rd_data;
	logic [3:0]            change;

	qioe_sync u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.reset_n_i (reset_n_i),
		.io_i      (io_i),
		.sync      (sync)
	);

	assign core_rst = rst_i | ~sync.rst_n;

	// ------------------------------------------------------------
	// Read mux and transfer strobes
	// ------------------------------------------------------------
	// command decode
	always_comb begin
		unique case (ptr_reg)
			qioe_pkg::CMD_INPUT:  rd_data = {qioe_pkg::IN_PAD, sync.pins ^ pol_reg};
			qioe_pkg::CMD_OUTPUT: rd_data = {qioe_pkg::OUT_PAD, out_reg};
			qioe_pkg::CMD_POLAR:  rd_data = {qioe_pkg::POL_PAD, pol_reg};
			qioe_pkg::CMD_DIR:    rd_data = {qioe_pkg::DIR_PAD, dir_reg};
			default:              rd_data = qioe_pkg::UNMAP_RD;
		endcase
	end

	assign wr_go   = sync.scl_fall & ~sync.start & ~sync.stop & (state_reg == qioe_pkg::ST_WDAT)
	                 & (bitcnt_reg == qioe_pkg::BIT_LAST);
	assign rd_load = sync.scl_fall & ~sync.start & ~sync.stop
	                 & (((state_reg == qioe_pkg::ST_AACK) & rw_reg) | ((state_reg == qioe_pkg::ST_RACK) & mack_reg));
	assign snap    = rd_load & (ptr_reg == qioe_pkg::CMD_INPUT);

	// ------------------------------------------------------------
	// Serial target state machine
	// ------------------------------------------------------------
	// write and read transactions
	always_ff @(posedge ref_clk_i) begin
		if (core_rst) begin
			state_reg  <= qioe_pkg::ST_IDLE;
			bitcnt_reg <= qioe_pkg::BIT_ZERO;
			shift_reg  <= qioe_pkg::CMD_RST;
			rw_reg     <= 1'b0;
			mack_reg   <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else if (sync.stop) begin
			state_reg  <= qioe_pkg::ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (sync.start) begin
			state_reg  <= qioe_pkg::ST_ADDR;
			bitcnt_reg <= qioe_pkg::BIT_ZERO;
			sda_oe_reg <= 1'b0;
		end else if (sync.scl_rise) begin
			if (state_reg == qioe_pkg::ST_ADDR || state_reg == qioe_pkg::ST_CMD ||
			    state_reg == qioe_pkg::ST_WDAT) begin
				shift_reg  <= {shift_reg[6:0], sync.sda};
				bitcnt_reg <= 4'(bitcnt_reg + 4'h1);
			end else if (state_reg == qioe_pkg::ST_RDAT) begin
				bitcnt_reg <= 4'(bitcnt_reg + 4'h1);
			end else if (state_reg == qioe_pkg::ST_RACK) begin
				mack_reg <= ~sync.sda;
			end
		end else if (sync.scl_fall) begin
			unique case (state_reg)
				qioe_pkg::ST_IDLE: begin
					sda_oe_reg <= 1'b0;
				end
				qioe_pkg::ST_ADDR: begin
					if (bitcnt_reg == qioe_pkg::BIT_LAST) begin
						if (shift_reg[7:1] == qioe_pkg::DEV_ADDR) begin
							state_reg  <= qioe_pkg::ST_AACK;
							rw_reg     <= shift_reg[0];
							sda_oe_reg <= 1'b1;
						end else begin
							state_reg <= qioe_pkg::ST_IDLE;
						end
					end
				end
				qioe_pkg::ST_AACK: begin
					bitcnt_reg <= qioe_pkg::BIT_ZERO;
					if (rw_reg) begin
						state_reg  <= qioe_pkg::ST_RDAT;
						shift_reg  <= {rd_data[6:0], 1'b0};
						sda_oe_reg <= ~rd_data[7];
					end else begin
						state_reg  <= qioe_pkg::ST_CMD;
						sda_oe_reg <= 1'b0;
					end
				end
				qioe_pkg::ST_CMD: begin
					if (bitcnt_reg == qioe_pkg::BIT_LAST) begin
						state_reg  <= qioe_pkg::ST_CACK;
						sda_oe_reg <= 1'b1;
					end
				end
				qioe_pkg::ST_CACK, qioe_pkg::ST_WACK: begin
					state_reg  <= qioe_pkg::ST_WDAT;
					bitcnt_reg <= qioe_pkg::BIT_ZERO;
					sda_oe_reg <= 1'b0;
				end
				qioe_pkg::ST_WDAT: begin
					if (bitcnt_reg == qioe_pkg::BIT_LAST) begin
						state_reg  <= qioe_pkg::ST_WACK;
						sda_oe_reg <= 1'b1;
					end
				end
				qioe_pkg::ST_RDAT: begin
					if (bitcnt_reg == qioe_pkg::BIT_LAST) begin
						state_reg  <= qioe_pkg::ST_RACK;
						sda_oe_reg <= 1'b0;
					end else begin
						shift_reg  <= {shift_reg[6:0], 1'b0};
						sda_oe_reg <= ~shift_reg[7];
					end
				end
				qioe_pkg::ST_RACK: begin
					bitcnt_reg <= qioe_pkg::BIT_ZERO;
					if (mack_reg) begin
						state_reg  <= qioe_pkg::ST_RDAT;
						shift_reg  <= {rd_data[6:0], 1'b0};
						sda_oe_reg <= ~rd_data[7];
					end else begin
						state_reg  <= qioe_pkg::ST_IDLE;
						sda_oe_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pointer and registers
	// ------------------------------------------------------------
	// pointer kept until next command
	always_ff @(posedge ref_clk_i) begin
		if (core_rst)
			ptr_reg <= qioe_pkg::CMD_RST;
		else if (sync.scl_fall & ~sync.start & ~sync.stop & (state_reg == qioe_pkg::ST_CMD)
		         & (bitcnt_reg == qioe_pkg::BIT_LAST))
			ptr_reg <= shift_reg;
	end

	// input register has no write path
	always_ff @(posedge ref_clk_i) begin
		if (core_rst) begin
			out_reg <= qioe_pkg::OUT_RST;
			pol_reg <= qioe_pkg::POL_RST;
			dir_reg <= qioe_pkg::DIR_RST;
		end else if (wr_go) begin
			if (ptr_reg == qioe_pkg::CMD_OUTPUT)
				out_reg <= shift_reg[3:0];
			if (ptr_reg == qioe_pkg::CMD_POLAR)
				pol_reg <= shift_reg[3:0];
			if (ptr_reg == qioe_pkg::CMD_DIR)
				dir_reg <= shift_reg[3:0];
		end
	end

	// ------------------------------------------------------------
	// Change detect interrupt
	// ------------------------------------------------------------
	// Reference is raw pin level so polarity flips cause no interrupt
	always_ff @(posedge ref_clk_i) begin
		if (core_rst | snap)
			ref_reg <= sync.pins;
	end

	assign change = (sync.pins ^ ref_reg) & dir_reg;

	always_ff @(posedge ref_clk_i) begin
		if (core_rst | snap)
			int_reg <= 1'b0;
		else
			int_reg <= |change;
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// input pins undriven
	// one driver picked by output bit
	always_ff @(posedge ref_clk_i) begin
		if (core_rst) begin
			io_reg    <= qioe_pkg::OUT_RST;
			io_oe_reg <= 4'h0;
			drv_a_reg <= 4'h0;
			drv_b_reg <= 4'h0;
		end else begin
			io_reg    <= out_reg;
			io_oe_reg <= ~dir_reg;
			drv_a_reg <= ~dir_reg & out_reg;
			drv_b_reg <= ~dir_reg & ~out_reg;
		end
	end

	// Open-drain lines only ever drive low
	always_ff @(posedge ref_clk_i) begin
		low_reg <= 1'b0;
	end

	assign sda_o          = low_reg;
	assign sda_oe_o       = sda_oe_reg;
	assign int_o          = low_reg;
	assign int_oe_o       = int_reg;
	assign io_o           = io_reg;
	assign io_oe_o        = io_oe_reg;
	assign pin_driver_a_o = drv_a_reg;
	assign pin_driver_b_o = drv_b_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_reset_defaults: assert property (@(posedge ref_clk_i) core_rst |=>
		(dir_reg == qioe_pkg::DIR_RST) && (out_reg == qioe_pkg::OUT_RST) && (state_reg == qioe_pkg::ST_IDLE))
		else $error("registers not at defaults after reset");

	a_int_open_drain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		int_oe_o |-> !int_o)
		else $error("interrupt line driven high");

	a_int_on_change: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		(|change && !snap) |=> int_oe_o)
		else $error("input change did not raise interrupt");

	a_int_drops: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		(change == 4'h0) |=> !int_oe_o)
		else $error("interrupt stayed without a change");

	a_read_rebase: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		snap |=> (ref_reg == $past(sync.pins)) && !int_oe_o)
		else $error("input read did not rebase");

	a_input_hiz: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		##1 ((pin_driver_a_o | pin_driver_b_o) & $past(dir_reg)) == 4'h0)
		else $error("driver on for input pin");

	a_one_driver: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		##1 ((pin_driver_a_o ^ pin_driver_b_o) == ~$past(dir_reg)) && (pin_driver_a_o == ($past(out_reg) & ~$past(dir_reg))))
		else $error("output driver choice wrong");

	a_no_autoinc: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		(state_reg inside {qioe_pkg::ST_WDAT, qioe_pkg::ST_RDAT, qioe_pkg::ST_RACK}) |=> $stable(ptr_reg))
		else $error("pointer moved during data bytes");

	a_polarity_read: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		(snap && state_reg == qioe_pkg::ST_AACK) |=> shift_reg[3:1] == $past(sync.pins[2:0] ^ pol_reg[2:0]))
		else $error("input read ignores polarity");

	a_input_readonly: assert property (@(posedge ref_clk_i) disable iff (core_rst)
		(wr_go && ptr_reg == qioe_pkg::CMD_INPUT) |=> $stable(out_reg) && $stable(pol_reg) && $stable(dir_reg))
		else $error("write to input register changed state");

endmodule

// ---- verification/qioe_host_model.sv ----
// Purpose: Behavioural serial bus host that drives SCL and pulls SDA low
// Assumes: Tasks are entered at a falling edge of clk_i
// Notes:   SCL idles high between frames; SDA is only ever pulled low

`timescale 1ns/10ps

module qioe_host_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// Quarter bit in ref clocks; keeps SCL high and low at 8 clocks each
	localparam int Q = 4;

	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic q_wait();
		repeat (Q) @(negedge clk_i);
	endtask

	// ------------------------------------------------------------
	// Frame conditions
	// ------------------------------------------------------------
	// start or repeated start
	task automatic start_cond();
		q_wait();
		sda_low_o = 1'b0;
		q_wait();
		scl_o = 1'b1;
		q_wait();
		sda_low_o = 1'b1;
		q_wait();
		scl_o = 1'b0;
	endtask

	task automatic stop_cond();
		q_wait();
		sda_low_o = 1'b1;
		q_wait();
		scl_o = 1'b1;
		q_wait();
		sda_low_o = 1'b0;
		q_wait();
	endtask

	// ------------------------------------------------------------
	// Bits and bytes
	// ------------------------------------------------------------
	// Data only changes while SCL is low, sampled mid-way through the high phase
	task automatic xfer_bit(input logic b, output logic r);
		q_wait();
		sda_low_o = ~b;
		q_wait();
		scl_o = 1'b1;
		q_wait();
		r = sda_i;
		q_wait();
		scl_o = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
		xfer_bit(1'b1, ack);
	endtask

	task automatic recv_byte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
		xfer_bit(~mack, r);
	endtask
endmodule

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the quad I/O expander core
// Assumes: Pins resolve from the two drivers, else the bench level
// Notes:   Every write sends two data bytes to expose pointer advance

`timescale 1ns/10ps

module tb_top;
	logic       ref_clk_i;
	logic       rst_i;
	logic       reset_n_i;
	logic       scl;
	logic       sda_low;
	logic       sda_w;
	logic [3:0] ext_pins;
	logic [3:0] io_w;
	logic       sda_o;
	logic       sda_oe_o;
	logic       int_o;
	logic       int_oe_o;
	logic [3:0] io_o;
	logic [3:0] io_oe_o;
	logic [3:0] pin_driver_a_o;
	logic [3:0] pin_driver_b_o;
	logic [7:0] dflt [5] = '{8'hf5, 8'hff, 8'h00, 8'hff, 8'hff};
	logic       ack;
	int         err_total = 0;
	int         checked = 0;

	// SDA has a pull-up; pins fall back to the bench level when undriven
	assign sda_w = !((sda_oe_o && !sda_o) || sda_low);
	assign io_w  = pin_driver_a_o | (~pin_driver_b_o & ext_pins);

	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	qioe_host_model host (.clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

	qioe_core uut (
		.ref_clk_i      (ref_clk_i),
		.rst_i          (rst_i),
		.reset_n_i      (reset_n_i),
		.scl_i          (scl),
		.sda_i          (sda_w),
		.sda_o          (sda_o),
		.sda_oe_o       (sda_oe_o),
		.int_o          (int_o),
		.int_oe_o       (int_oe_o),
		.io_i           (io_w),
		.io_o           (io_o),
		.io_oe_o        (io_oe_o),
		.pin_driver_a_o (pin_driver_a_o),
		.pin_driver_b_o (pin_driver_b_o)
	);

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %0s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
		logic a0, a1, a2;
		host.start_cond();
		host.send_byte({qioe_pkg::DEV_ADDR, 1'b0}, a0);
		host.send_byte(cmd, a1);
		host.send_byte(d0, a2);
		host.send_byte(d1, a2);
		host.stop_cond();
		chk("write acks", 8'h00, {6'h00, a0, a1});
	endtask

	// Reads two bytes; without auto-increment both come from one register
	task automatic rd_chk(input logic set_ptr, input logic [7:0] cmd, input logic [7:0] exp, input string what);
		logic       a0, a1;
		logic [7:0] d0, d1;
		a1 = 1'b0;
		if (set_ptr) begin
			host.start_cond();
			host.send_byte({qioe_pkg::DEV_ADDR, 1'b0}, a0);
			host.send_byte(cmd, a1);
		end
		host.start_cond();
		host.send_byte({qioe_pkg::DEV_ADDR, 1'b1}, a0);
		host.recv_byte(1'b1, d0);
		host.recv_byte(1'b0, d1);
		host.stop_cond();
		chk("read acks", 8'h00, {6'h00, a0, a1});
		chk(what, exp, d0);
		chk(what, exp, d1);
	endtask

	task automatic settle();
		repeat (10) @(negedge ref_clk_i);
	endtask

	task automatic done(input string name);
		$display("test %0s finished", name);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		reset_n_i = 1'b1;
		ext_pins = 4'h5;
		repeat (6) @(negedge ref_clk_i);
		rst_i = 1'b0;
		settle();
		chk("pin enables", 8'h00, {4'h0, io_oe_o});
		chk("drivers", 8'h00, {pin_driver_a_o, pin_driver_b_o});
		chk("int level", 8'h00, {7'h00, int_o});
		chk("int after reset", 8'h00, {7'h00, int_oe_o});
		chk("sda level", 8'h00, {7'h00, sda_o});
		chk("pin levels", 8'h0f, {4'h0, io_o});
		for (int c = 0; c < 5; c++) rd_chk(1'b1, 8'(c), dflt[c], "reg default");
		done("defaults");

		wr_reg(8'h03, 8'hf3, 8'hf3);
		wr_reg(8'h01, 8'h55, 8'hfa);
		settle();
		chk("pin enables", 8'h0c, {4'h0, io_oe_o});
		chk("drivers", 8'h84, {pin_driver_a_o, pin_driver_b_o});
		chk("pin levels", 8'h0a, {4'h0, io_o});
		chk("int on output", 8'h00, {7'h00, int_oe_o});
		rd_chk(1'b1, 8'h02, 8'h00, "polarity kept");
		rd_chk(1'b1, 8'h01, 8'hfa, "output reg");
		rd_chk(1'b0, 8'h01, 8'hfa, "pointer kept");
		wr_reg(8'h00, 8'h00, 8'h00);
		rd_chk(1'b1, 8'h00, 8'hf9, "input reg");
		wr_reg(8'h02, 8'hf1, 8'hf1);
		rd_chk(1'b1, 8'h00, 8'hf8, "inverted input");
		wr_reg(8'h02, 8'h00, 8'h00);
		done("registers");

		rd_chk(1'b1, 8'h00, 8'hf9, "input reg");
		ext_pins[0] = 1'b0;
		settle();
		chk("int on change", 8'h01, {7'h00, int_oe_o});
		ext_pins[0] = 1'b1;
		settle();
		chk("int on return", 8'h00, {7'h00, int_oe_o});
		ext_pins[1] = 1'b1;
		settle();
		chk("int on change", 8'h01, {7'h00, int_oe_o});
		rd_chk(1'b0, 8'h00, 8'hfb, "input reg");
		chk("int after read", 8'h00, {7'h00, int_oe_o});
		ext_pins[1] = 1'b0;
		settle();
		chk("int new base", 8'h01, {7'h00, int_oe_o});
		chk("int level", 8'h00, {7'h00, int_o});
		rd_chk(1'b0, 8'h00, 8'hf9, "input reg");
		wr_reg(8'h03, 8'hff, 8'hff);
		settle();
		chk("int on turn", 8'h01, {7'h00, int_oe_o});
		rd_chk(1'b1, 8'h00, 8'hf5, "input reg");
		chk("int after read", 8'h00, {7'h00, int_oe_o});
		done("interrupt");

		host.start_cond();
		host.send_byte({qioe_pkg::DEV_ADDR ^ 7'h01, 1'b0}, ack);
		host.stop_cond();
		chk("foreign address", 8'h01, {7'h00, ack});
		done("address");

		wr_reg(8'h03, 8'hf0, 8'hf0);
		settle();
		chk("pin enables", 8'h0f, {4'h0, io_oe_o});
		reset_n_i = 1'b0;
		settle();
		chk("held enables", 8'h00, {4'h0, io_oe_o});
		chk("held drivers", 8'h00, {pin_driver_a_o, pin_driver_b_o});
		chk("held levels", 8'h0f, {4'h0, io_o});
		host.start_cond();
		host.send_byte({qioe_pkg::DEV_ADDR, 1'b0}, ack);
		host.stop_cond();
		chk("ack in reset", 8'h01, {7'h00, ack});
		reset_n_i = 1'b1;
		settle();
		rd_chk(1'b1, 8'h03, 8'hff, "direction reset");
		done("reset pin");
		tally_and_finish();
	end

	// Whole run needs about 0.15 ms; allow about three times that
	initial begin
		#500_000;
		err_total++;
		tally_and_finish();
	end
endmodule
